// ==== rtl/psc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the
// start-up and configuration controller. Assumes APB with 32-bit data.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// Register byte offsets
`define PSC_CTRL_OFF        12'h000
`define PSC_CHCFG_OFF       12'h004
`define PSC_PHASE_OFF       12'h008
`define PSC_GPIOCFG_OFF     12'h00c
`define PSC_STATUS_OFF      12'h010
`define PSC_IRQ_STAT_OFF    12'h014
`define PSC_IRQ_MASK_OFF    12'h018
`define PSC_OTP_ADDR_OFF    12'h01c
`define PSC_OTP_DATA_OFF    12'h020
`define PSC_TARGET_OFF      12'h024
`define PSC_STOP_OFF        12'h028
`define PSC_RAMP_OFF        12'h02c
`define PSC_DELAY_OFF       12'h030
`define PSC_VOUT_OFF        12'h034

// Control register fields
`define PSC_CTRL_SOFTRST    0
`define PSC_CTRL_OTP_PROG   1
`define PSC_CTRL_I2C_USE    2

// Configuration store layout: one word per entry
`define PSC_OTP_WORDS       8
`define PSC_OTP_AW          3
`define PSC_OTP_CHCFG       3'h0
`define PSC_OTP_PHASE       3'h1
`define PSC_OTP_GPIOCFG     3'h2
`define PSC_OTP_TARGET      3'h3
`define PSC_OTP_STOP        3'h4
`define PSC_OTP_RAMP        3'h5
`define PSC_OTP_DELAY       3'h6

// Channel config nibble per channel: [0] always-on, [1] gpio enable,
// [3:2] gpio index; bit 16 selects the common enable input mode
`define PSC_CH_ALWAYS       0
`define PSC_CH_GPIO_EN      1
`define PSC_CH_GPIO_LO      2
`define PSC_CHCFG_COMMON    16

// Interrupt bits
`define PSC_IRQ_READY       0
`define PSC_IRQ_SHUTDN      1
`define PSC_IRQ_OTP_DONE    2
`define PSC_IRQ_W           3

// GPIO function codes: 1 to 5 drive the pin as output, 0 and 7 are inputs
`define PSC_GF_INPUT        3'h0
`define PSC_GF_OCF          3'h1
`define PSC_GF_OVF          3'h2
`define PSC_GF_TEMP         3'h3
`define PSC_GF_SS           3'h4
`define PSC_GF_PGOOD        3'h5
`define PSC_GF_COMEN        3'h7

// Enable-low shutdown filter: 100 us at 100 ns per cycle
`define PSC_SHDN_US         100
`define PSC_CLK_NS          100
`define PSC_SHDN_CYC        ((`PSC_SHDN_US * 1000) / `PSC_CLK_NS)
`define PSC_ONE8            8'h01
`define PSC_ZERO32          32'h0000_0000

`endif

// ==== rtl/psc_pkg.sv ====
// Types shared by the start-up and configuration controller.
// Assumes the constant header psc_regs.svh is available.
package psc_pkg;
    typedef enum logic [2:0] {
        PSC_OFF   = 3'h0,
        PSC_LOAD  = 3'h1,
        PSC_READY = 3'h3
    } psc_state_t;

    typedef enum logic [1:0] {
        CH_IDLE  = 2'h0,
        CH_DELAY = 2'h1,
        CH_RAMP  = 2'h3,
        CH_STOP  = 2'h2
    } psc_ch_state_t;

    typedef struct packed {
        logic       on;
        logic       drive;
        logic [7:0] ref_v;
    } psc_ch_out_t;

    typedef struct packed {
        logic [3:0] over_current_fault;
        logic [3:0] over_voltage_fault;
        logic       temp_fault;
    } psc_faults_t;
endpackage

// ==== rtl/psc_ctrl.sv ====
// Start-up and configuration control: configuration store copy, chip-ready,
// channel enable, soft start / soft stop ramps, phases and GPIO sharing.
// Assumes an APB master on pclk; pins pass through two-flop synchronisers.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"

module psc_ctrl (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                enable_pin,
    input  wire logic                serial_chip_reset_command,
    input  wire logic [5:0]          gpio_in,
    output logic      [5:0]          gpio_out,
    output logic      [5:0]          gpio_oe_n,
    input  wire psc_pkg::psc_faults_t faults,
    input  wire logic [31:0]         vout_meas,
    output logic                     chip_ready,
    output logic                     serial_ack_en,
    output logic      [3:0]          ch_on,
    output logic      [3:0]          high_gate,
    output logic      [3:0]          low_gate,
    output logic      [7:0]          ch_phase,
    output logic      [31:0]         ch_ref,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] en_s_r;
    logic [1:0] srst_s_r;
    logic [5:0] gpio_m_r;
    logic [5:0] gpio_s_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_s_r   <= 2'h0;
            srst_s_r <= 2'h0;
            gpio_m_r <= 6'h00;
            gpio_s_r <= 6'h00;
        end else begin
            en_s_r   <= {en_s_r[0], enable_pin};
            srst_s_r <= {srst_s_r[0], serial_chip_reset_command};
            gpio_m_r <= gpio_in;
            gpio_s_r <= gpio_m_r;
        end
    end
    wire logic en_lvl   = en_s_r[1];
    logic      srst_d_r;
    wire logic srst_evt = srst_s_r[1] & ~srst_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers and configuration store
    logic [31:0] otp_mem [`PSC_OTP_WORDS];
    logic [31:0] ctrl_r, chcfg_r, phase_r, gpiocfg_r, target_r, stop_r;
    logic [31:0] ramp_r, delay_r;
    logic [`PSC_IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic [`PSC_OTP_AW-1:0] otp_addr_r, ld_idx_r;
    psc_pkg::psc_state_t st_r;
    logic [15:0] shdn_cnt_r;
    logic [`PSC_IRQ_W-1:0] ev;

    wire logic wr_en = psel & penable & pwrite;
    wire logic loading = (st_r == psc_pkg::PSC_LOAD);
    wire logic ld_last = (ld_idx_r == `PSC_OTP_AW'(`PSC_OTP_WORDS - 1));

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // Power-up copy overrides software; both are the same register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chcfg_r   <= `PSC_ZERO32;
            phase_r   <= `PSC_ZERO32;
            gpiocfg_r <= `PSC_ZERO32;
            target_r  <= `PSC_ZERO32;
            stop_r    <= `PSC_ZERO32;
            ramp_r    <= `PSC_ZERO32;
            delay_r   <= `PSC_ZERO32;
        end else if (loading) begin
            case (ld_idx_r)
                `PSC_OTP_CHCFG:   chcfg_r   <= otp_mem[ld_idx_r];
                `PSC_OTP_PHASE:   phase_r   <= otp_mem[ld_idx_r];
                `PSC_OTP_GPIOCFG: gpiocfg_r <= otp_mem[ld_idx_r];
                `PSC_OTP_TARGET:  target_r  <= otp_mem[ld_idx_r];
                `PSC_OTP_STOP:    stop_r    <= otp_mem[ld_idx_r];
                `PSC_OTP_RAMP:    ramp_r    <= otp_mem[ld_idx_r];
                `PSC_OTP_DELAY:   delay_r   <= otp_mem[ld_idx_r];
                default: ;
            endcase
        end else if (wr_en) begin
            if (hit(paddr, `PSC_CHCFG_OFF))   chcfg_r   <= pwdata;
            if (hit(paddr, `PSC_PHASE_OFF))   phase_r   <= pwdata;
            if (hit(paddr, `PSC_GPIOCFG_OFF)) gpiocfg_r <= pwdata;
            if (hit(paddr, `PSC_TARGET_OFF))  target_r  <= pwdata;
            if (hit(paddr, `PSC_STOP_OFF))    stop_r    <= pwdata;
            if (hit(paddr, `PSC_RAMP_OFF))    ramp_r    <= pwdata;
            if (hit(paddr, `PSC_DELAY_OFF))   delay_r   <= pwdata;
        end
    end

    // Control: soft-reset and program bits self-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `PSC_ZERO32;
            otp_addr_r <= '0;
        end else begin
            ctrl_r[`PSC_CTRL_SOFTRST]  <= wr_en & hit(paddr, `PSC_CTRL_OFF)
                                          & pwdata[`PSC_CTRL_SOFTRST];
            ctrl_r[`PSC_CTRL_OTP_PROG] <= wr_en & hit(paddr, `PSC_CTRL_OFF)
                                          & pwdata[`PSC_CTRL_OTP_PROG];
            if (wr_en && hit(paddr, `PSC_CTRL_OFF))
                ctrl_r[`PSC_CTRL_I2C_USE] <= pwdata[`PSC_CTRL_I2C_USE];
            if (wr_en && hit(paddr, `PSC_OTP_ADDR_OFF))
                otp_addr_r <= pwdata[`PSC_OTP_AW-1:0];
        end
    end

    // One-time store: programming only takes bits from 0 to 1; presetn clears every word
    logic [31:0] otp_wdata_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_wdata_r <= `PSC_ZERO32;
            for (int i = 0; i < `PSC_OTP_WORDS; i++)
                otp_mem[i] <= `PSC_ZERO32;
        end else begin
            if (wr_en && hit(paddr, `PSC_OTP_DATA_OFF))
                otp_wdata_r <= pwdata;
            if (ctrl_r[`PSC_CTRL_OTP_PROG])
                otp_mem[otp_addr_r] <= otp_mem[otp_addr_r] | otp_wdata_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up sequencer and enable-low filter
    wire logic shdn_now = (shdn_cnt_r == 16'(`PSC_SHDN_CYC));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shdn_cnt_r <= 16'h0000;
            srst_d_r   <= 1'b0;
        end else begin
            srst_d_r <= srst_s_r[1];
            if (en_lvl)
                shdn_cnt_r <= 16'h0000;
            else if (!shdn_now)
                shdn_cnt_r <= shdn_cnt_r + 16'h0001;
        end
    end

    wire logic soft_rst = srst_evt | ctrl_r[`PSC_CTRL_SOFTRST];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= psc_pkg::PSC_OFF;
            ld_idx_r <= '0;
        end else begin
            case (st_r)
                psc_pkg::PSC_OFF: begin
                    ld_idx_r <= '0;
                    if (en_lvl)
                        st_r <= psc_pkg::PSC_LOAD;
                end
                psc_pkg::PSC_LOAD: begin
                    ld_idx_r <= ld_idx_r + `PSC_OTP_AW'(1);
                    if (ld_last)
                        st_r <= psc_pkg::PSC_READY;
                end
                psc_pkg::PSC_READY: begin
                    if (shdn_now || soft_rst)
                        st_r <= psc_pkg::PSC_OFF;
                end
                default: st_r <= psc_pkg::PSC_OFF;
            endcase
        end
    end
    wire logic ready = (st_r == psc_pkg::PSC_READY);
    logic ready_d_r;
    wire logic ready_rise = ready & ~ready_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Channels
    logic [3:0] en_r;
    logic [3:0] ss_act;
    logic [3:0] pgood;
    wire logic common_mode = chcfg_r[`PSC_CHCFG_COMMON];

    function automatic logic gpio_sel(input logic [3:0] cfg, input logic [5:0] g);
        gpio_sel = g[cfg[`PSC_CH_GPIO_LO +: 2]];
    endfunction

    // Common enable: last GPIO set as input with function code 7
    logic com_en;
    always_comb begin
        com_en = 1'b1;
        for (int i = 0; i < 6; i++)
            if (gpiocfg_r[i*4 +: 3] == `PSC_GF_COMEN)
                com_en = gpio_s_r[i];
    end

    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            wire logic [3:0] cfg = chcfg_r[c*4 +: 4];
            psc_pkg::psc_ch_state_t cs_r;
            logic [7:0] cnt_r;
            logic [7:0] ref_r;
            wire logic [7:0] tgt  = target_r[c*8 +: 8];
            wire logic [7:0] stp  = stop_r[c*8 +: 8];
            wire logic [7:0] rate = ramp_r[c*8 +: 8];
            wire logic [7:0] meas = vout_meas[c*8 +: 8];
            wire logic want = en_r[c] & (~common_mode | com_en);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    en_r[c] <= 1'b0;
                else if (!ready)
                    en_r[c] <= 1'b0;
                else if (ready_rise)
                    en_r[c] <= cfg[`PSC_CH_ALWAYS]
                        | (cfg[`PSC_CH_GPIO_EN] & gpio_sel(cfg, gpio_s_r));
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cs_r  <= psc_pkg::CH_IDLE;
                    cnt_r <= 8'h00;
                    ref_r <= 8'h00;
                end else if (!ready) begin
                    cs_r  <= psc_pkg::CH_IDLE;
                    ref_r <= 8'h00;
                end else begin
                    case (cs_r)
                        psc_pkg::CH_IDLE: begin
                            cnt_r <= delay_r[c*8 +: 8];
                            if (want)
                                cs_r <= psc_pkg::CH_DELAY;
                        end
                        psc_pkg::CH_DELAY: begin
                            cnt_r <= cnt_r - `PSC_ONE8;
                            if (!want)
                                cs_r <= psc_pkg::CH_IDLE;
                            else if (cnt_r == 8'h00)
                                cs_r <= psc_pkg::CH_RAMP;
                        end
                        psc_pkg::CH_RAMP: begin
                            if (!want)
                                cs_r <= psc_pkg::CH_STOP;
                            else if (ref_r < tgt)
                                ref_r <= (tgt - ref_r > rate) ? ref_r + rate : tgt;
                        end
                        psc_pkg::CH_STOP: begin
                            if (ref_r > stp)
                                ref_r <= (ref_r - stp > rate) ? ref_r - rate : stp;
                            else begin
                                ref_r <= 8'h00;
                                cs_r  <= psc_pkg::CH_IDLE;
                            end
                        end
                        default: cs_r <= psc_pkg::CH_IDLE;
                    endcase
                end
            end

            wire logic run = (cs_r == psc_pkg::CH_RAMP) | (cs_r == psc_pkg::CH_STOP);
            wire logic drive = run & (ref_r > meas);
            assign ss_act[c] = (cs_r == psc_pkg::CH_RAMP) & (ref_r != tgt);
            assign pgood[c]  = (cs_r == psc_pkg::CH_RAMP) & (ref_r == tgt);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ch_on[c]     <= 1'b0;
                    high_gate[c] <= 1'b0;
                    low_gate[c]  <= 1'b0;
                    ch_ref[c*8 +: 8]   <= 8'h00;
                    ch_phase[c*2 +: 2] <= 2'h0;
                end else begin
                    ch_on[c]     <= run & ready;
                    high_gate[c] <= drive & ready;
                    low_gate[c]  <= drive & ready;
                    ch_ref[c*8 +: 8]   <= ref_r;
                    ch_phase[c*2 +: 2] <= phase_r[c*2 +: 2];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // GPIO pins: 4 and 5 become serial data and clock when in use
    function automatic logic gpio_func(input logic [2:0] f, input logic [3:0] ss,
                                       input logic [3:0] pg,
                                       input psc_pkg::psc_faults_t flt);
        case (f)
            `PSC_GF_OCF:   gpio_func = |flt.over_current_fault;
            `PSC_GF_OVF:   gpio_func = |flt.over_voltage_fault;
            `PSC_GF_TEMP:  gpio_func = flt.temp_fault;
            `PSC_GF_SS:    gpio_func = |ss;
            `PSC_GF_PGOOD: gpio_func = &pg;
            default:       gpio_func = 1'b0;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_gpio
            wire logic [2:0] fn = gpiocfg_r[g*4 +: 3];
            wire logic serial = (g >= 4) & ctrl_r[`PSC_CTRL_I2C_USE];
            wire logic is_out = ~serial & (fn >= `PSC_GF_OCF) & (fn <= `PSC_GF_PGOOD);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gpio_out[g]  <= 1'b0;
                    gpio_oe_n[g] <= 1'b1;
                end else begin
                    gpio_out[g]  <= gpio_func(fn, ss_act, pgood, faults);
                    gpio_oe_n[g] <= ~is_out;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Interrupts, status and APB slave
    assign ev = {ctrl_r[`PSC_CTRL_OTP_PROG], shdn_now & ready, ready_rise};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r    <= '0;
            irq_mask_r    <= '0;
            ready_d_r     <= 1'b0;
            irq           <= 1'b0;
            chip_ready    <= 1'b0;
            serial_ack_en <= 1'b0;
        end else begin
            ready_d_r <= ready;
            if (wr_en && hit(paddr, `PSC_IRQ_STAT_OFF))
                irq_stat_r <= (irq_stat_r & ~pwdata[`PSC_IRQ_W-1:0]) | ev;
            else
                irq_stat_r <= irq_stat_r | ev;
            if (wr_en && hit(paddr, `PSC_IRQ_MASK_OFF))
                irq_mask_r <= pwdata[`PSC_IRQ_W-1:0];
            // Mask bit set blocks its status bit
            irq           <= |(irq_stat_r & ~irq_mask_r);
            chip_ready    <= ready;
            serial_ack_en <= ready;
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `PSC_ZERO32;
        case (paddr)
            `PSC_CTRL_OFF:     rd_mux = ctrl_r;
            `PSC_CHCFG_OFF:    rd_mux = chcfg_r;
            `PSC_PHASE_OFF:    rd_mux = phase_r;
            `PSC_GPIOCFG_OFF:  rd_mux = gpiocfg_r;
            `PSC_STATUS_OFF:   rd_mux = {20'h0, gpio_s_r, en_r, st_r == psc_pkg::PSC_LOAD,
                                         ready};
            `PSC_IRQ_STAT_OFF: rd_mux = {29'h0, irq_stat_r};
            `PSC_IRQ_MASK_OFF: rd_mux = {29'h0, irq_mask_r};
            `PSC_OTP_ADDR_OFF: rd_mux = {29'h0, otp_addr_r};
            `PSC_OTP_DATA_OFF: rd_mux = otp_mem[otp_addr_r];
            `PSC_TARGET_OFF:   rd_mux = target_r;
            `PSC_STOP_OFF:     rd_mux = stop_r;
            `PSC_RAMP_OFF:     rd_mux = ramp_r;
            `PSC_DELAY_OFF:    rd_mux = delay_r;
            `PSC_VOUT_OFF:     rd_mux = vout_meas;
            default:           rd_mux = `PSC_ZERO32;
        endcase
    end

    wire logic mapped = (paddr <= `PSC_VOUT_OFF) & (paddr[1:0] == 2'h0);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= `PSC_ZERO32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite)
                prdata <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// ==== sim/psc_ctrl_sva.sv ====
// Checker for the start-up controller, watching its top-level ports only.
// Assumes a 10 MHz pclk and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        enable_pin,
    input wire logic        serial_chip_reset_command,
    input wire logic        chip_ready,
    input wire logic        serial_ack_en,
    input wire logic [3:0]  ch_on,
    input wire logic [3:0]  high_gate,
    input wire logic [3:0]  low_gate,
    input wire logic [31:0] ch_ref,
    input wire logic [31:0] vout_meas
);
    logic [10:0] low_cnt_r;
    // Saturating count of enable-low cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt_r <= 11'h000;
        else if (enable_pin) low_cnt_r <= 11'h000;
        else if (low_cnt_r != 11'h7ff) low_cnt_r <= low_cnt_r + 11'h001;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_ready_rise; $rose(chip_ready); endsequence
    a_ack_follows_ready: assert property (serial_ack_en == chip_ready)
        else $error("serial acknowledge differs from chip ready");
    a_idle_no_drive: assert property (!chip_ready && !$past(chip_ready) |->
        ch_on == 4'h0 && high_gate == 4'h0 && low_gate == 4'h0)
        else $error("channel active without chip ready");
    a_gate_pair: assert property (high_gate == low_gate)
        else $error("gate drives disagree");
    a_prebias_hold: assert property ($rose(high_gate[0]) |->
        ch_ref[7:0] > vout_meas[7:0])
        else $error("gates on before reference passed output");
    a_load_first: assert property (s_ready_rise |-> $past(enable_pin, 8))
        else $error("ready rose before store copy time");
    a_shdn_long: assert property (low_cnt_r == 11'h3f2 |-> !chip_ready)
        else $error("no shutdown after long enable low");
    a_shdn_short: assert property (chip_ready && !serial_chip_reset_command &&
        low_cnt_r != 11'h000 && low_cnt_r < 11'h3de |=> chip_ready)
        else $error("shutdown on short enable low");
    a_apb_answer: assert property (s_setup |=> pready)
        else $error("no answer in access cycle");
    a_pready_once: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_soft_reset: assert property ($rose(serial_chip_reset_command) && chip_ready
        |-> ##[1:8] !chip_ready)
        else $error("soft reset ignored");
    a_ready_rise: assert property ($rose(enable_pin) && !chip_ready
        |-> ##[1:20] chip_ready)
        else $error("ready late after enable");
endmodule
bind psc_ctrl psc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .enable_pin, .serial_chip_reset_command, .chip_ready, .serial_ack_en,
    .ch_on, .high_gate, .low_gate, .ch_ref, .vout_meas);
`default_nettype wire

// ==== sim/psc_power_stage.sv ====
// Power stage model: pre-biased outputs and fault lines.
// Assumes the output voltages stay at their pre-bias level.
`timescale 1ns/1ps
`default_nettype none
module psc_power_stage #(
    parameter logic [31:0] PREBIAS = 32'h2020_2030
) (
    output logic [31:0]           vout_meas,
    output psc_pkg::psc_faults_t  faults
);
    assign vout_meas = PREBIAS;
    assign faults    = '0;
endmodule
`default_nettype wire

// ==== sim/tb_psc_ctrl.sv ====
// Testbench for the start-up controller: APB tasks and directed sequences.
// Assumes the checker is bound and the power stage model is present.
`timescale 1ns/1ps
`default_nettype none
`include "psc_regs.svh"
module tb_psc_ctrl;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, enable_pin = 1'b0, cmd = 1'b0;
    logic        chip_ready, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, vout_meas, ch_ref, rd;
    logic [5:0]  gpio_in = 6'h04;
    logic [5:0]  gpio_out, gpio_oe_n;
    logic [3:0]  ch_on, high_gate, low_gate;
    logic [7:0]  ch_phase;
    psc_pkg::psc_faults_t faults;
    int num_errors = 0, n_compared = 0;
    always #50 pclk = ~pclk;
    psc_power_stage u_stage (.vout_meas(vout_meas), .faults(faults));
    psc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .enable_pin, .serial_chip_reset_command(cmd),
        .gpio_in, .gpio_out, .gpio_oe_n, .faults, .vout_meas, .chip_ready,
        .serial_ack_en(), .ch_on, .high_gate, .low_gate, .ch_phase, .ch_ref,
        .irq);
    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wait_ready(input logic v);
        int n;
        for (n = 0; chip_ready !== v; n++) begin
            if (n > 100) begin
                num_errors++;
                finish_test();
            end
            @(posedge pclk);
        end
    endtask
    task automatic prog(input logic [2:0] a, input logic [31:0] d);
        apb(1'b1, `PSC_OTP_ADDR_OFF, {29'h0, a});
        apb(1'b1, `PSC_OTP_DATA_OFF, d);
        apb(1'b1, `PSC_CTRL_OFF, 32'h0000_0002);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        prog(`PSC_OTP_CHCFG, 32'h0000_0ea1);
        prog(`PSC_OTP_CHCFG, 32'h0000_0000);
        prog(`PSC_OTP_TARGET, 32'h4040_4040);
        prog(`PSC_OTP_RAMP, 32'h1010_1010);
        prog(`PSC_OTP_DELAY, 32'h0303_0303);
        chk({28'h0, ch_on}, 32'h0);
        enable_pin <= 1'b1;
        wait_ready(1'b1);
        apb(1'b0, `PSC_CHCFG_OFF, 32'h0);
        chk(rd, 32'h0000_0ea1);
        repeat (30) @(posedge pclk);
        chk({28'h0, ch_on}, 32'h3);
        chk({28'h0, high_gate}, 32'h3);
        chk({24'h0, ch_ref[7:0]}, 32'h40);
        apb(1'b1, `PSC_PHASE_OFF, 32'h0000_00e4);
        repeat (2) @(posedge pclk);
        chk({24'h0, ch_phase}, 32'he4);
        // Pins 4/5 serial; pin 0 soft-start out, pin 4 set to soft-start but not driven as serial, pin 3 common enable
        apb(1'b1, `PSC_CTRL_OFF, 32'h0000_0004);
        apb(1'b1, `PSC_GPIOCFG_OFF, 32'h0004_7004);
        apb(1'b1, `PSC_CHCFG_OFF, 32'h0001_0ea1);
        repeat (20) @(posedge pclk);
        chk({28'h0, ch_on}, 32'h0);
        chk({24'h0, ch_ref[7:0]}, 32'h0);
        chk({26'h0, gpio_oe_n}, 32'h3e);
        gpio_in <= 6'h0c;
        repeat (30) @(posedge pclk);
        chk({28'h0, ch_on}, 32'h3);
        chk({26'h0, gpio_out}, 32'h0);
        apb(1'b1, `PSC_VOUT_OFF, 32'h0);
        apb(1'b0, `PSC_VOUT_OFF, 32'h0);
        chk(rd, 32'h2020_2030);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, `PSC_IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h5);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `PSC_IRQ_MASK_OFF, 32'h7);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `PSC_IRQ_MASK_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `PSC_IRQ_STAT_OFF, 32'h7);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        enable_pin <= 1'b0;
        repeat (500) @(posedge pclk);
        enable_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({31'h0, chip_ready}, 32'h1);
        enable_pin <= 1'b0;
        repeat (1100) @(posedge pclk);
        chk({27'h0, chip_ready, ch_on}, 32'h0);
        apb(1'b0, `PSC_IRQ_STAT_OFF, 32'h0);
        chk(rd, 32'h2);
        enable_pin <= 1'b1;
        wait_ready(1'b1);
        cmd <= 1'b1;
        wait_ready(1'b0);
        cmd <= 1'b0;
        wait_ready(1'b1);
        apb(1'b0, `PSC_CHCFG_OFF, 32'h0);
        chk(rd, 32'h0000_0ea1);
        finish_test();
    end
endmodule
`default_nettype wire
